// File: rtl/dce_defines.svh
// constants for the dual comparator event control block
// Contract
// RULE1: two comparators, combinable into one window comparator with two thresholds
// RULE2: a crossing gives a rising or falling output edge, per polarity setting
// RULE3: each comparator raises its own interrupt, able to wake from halt
// RULE4: second output routes to timer one break/clear or timer two/three capture 2
// RULE5: second comparator speed setting is software programmable
// RULE6: with converter enabled, it owns fifteen switches, closing at most one
// RULE7: software avoids first comparator with converter, except group 8 window
// RULE8: software avoids second comparator with converter, except group 8 input
// RULE9: software connects reference, closes switch fourteen and group switch first
// RULE10: software may enable interrupt, then nonzero edge field enables comparator
// RULE11: input channel may change while a comparator is enabled
// RULE12: software first selects second comparator inverting source, three bits
// RULE13: second non-inverting input comes only from group 8 pins
// RULE14: software sets window enable after reference and inverting source setup
// RULE15: in window mode only group 8 pins serve as shared input
// RULE16: window codes above 10,00 below 00,01 inside 01,10 outside 10,01
// RULE17: wait modes leave comparators alone; any comparator interrupt exits them
// RULE18: halt modes leave comparators alone; any comparator interrupt exits them
// RULE19: with reference stopped by ultra-low-power bit, no halt wakeup
// RULE20: first event flag gated by its enable is a wait and halt exit source
// RULE21: second event flag gated by its enable is a wait and halt exit source
// RULE22: edge field 00 off, 01 falling, 10 rising, 11 both edges
// RULE23: flag set on selected edge, cleared only by writing zero
// RULE24: route field 00 timer two, 01 timer three, 10 break, 11 reference clear
// RULE25: read-only bit per comparator mirrors its current output level
// RULE26: comparator outputs pass two flip-flops before edge detection
// RULE27: reset clears enables, edge fields and flags
`ifndef DCE_DEFINES_SVH
`define DCE_DEFINES_SVH
`define DCE_OFS_FIRST 32'h0000_0000
`define DCE_OFS_SECOND 32'h0000_0004
`define DCE_OFS_SHARED 32'h0000_0008
`define DCE_OFS_SWITCH 32'h0000_000C
`define DCE_OFS_POWER 32'h0000_0010
`define DCE_BIT_IE 5
`define DCE_BIT_EF 4
`define DCE_BIT_OUT 3
`define DCE_BIT_AUX 2
`define DCE_RST_FIRST 8'h00
`define DCE_RST_SECOND 8'h00
`define DCE_RST_SHARED 8'hC0
`define DCE_EDGE_OFF 2'b00
`define DCE_EDGE_FALL 2'b01
`define DCE_EDGE_RISE 2'b10
`define DCE_EDGE_BOTH 2'b11
`define DCE_ROUTE_T2 2'b00
`define DCE_ROUTE_T3 2'b01
`define DCE_ROUTE_BRK 2'b10
`define DCE_ROUTE_CLR 2'b11
`define DCE_NUM_SW 15
`define DCE_SW_FOURTEEN 14
`define DCE_RESP_OKAY 2'b00
`define DCE_RESP_SLVERR 2'b10
`endif

// File: rtl/dce_pkg.sv
// types shared by the comparator event control block
package dce_pkg;
   typedef struct packed {
      logic [1:0] edge_sel;
      logic irq_en;
      logic aux;
   } dce_cmp_cfg_type;
   typedef struct packed {
      logic [1:0] second_output_route;
      logic [2:0] second_inverting_source;
      logic reference_to_first_inverting;
      logic window_enable;
      logic reference_out_enable;
   } dce_shared_type;
   typedef enum logic [2:0] {
      DCE_IDLE = 3'b001,
      DCE_WRESP = 3'b010,
      DCE_RRESP = 3'b100
   } dce_bus_state_type;
endpackage : dce_pkg

// File: rtl/dce_edge_detect.sv
// synchroniser and selectable edge detector for one comparator output
`timescale 1ns/1ps
`include "dce_defines.svh"
module dce_edge_detect (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_cmp_out,
   input wire logic [1:0] i_edge_sel,
   output logic o_level,
   output logic o_event
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic rise;
   logic fall;
   always_comb begin
      sync_next = {sync_reg[1:0], i_cmp_out}; // RULE26
   end
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         sync_reg <= 3'h0;
      end else begin
         sync_reg <= sync_next;
      end
   end
   // only stages one and two feed logic; stage zero is the metastable one
   assign rise = sync_reg[1] & ~sync_reg[2];
   assign fall = ~sync_reg[1] & sync_reg[2];
   assign o_level = sync_reg[1]; // RULE25
   always_comb begin
      case (i_edge_sel) // RULE22
         `DCE_EDGE_FALL: o_event = fall;
         `DCE_EDGE_RISE: o_event = rise;
         `DCE_EDGE_BOTH: o_event = rise | fall;
         default: o_event = 1'b0;
      endcase
   end
endmodule : dce_edge_detect

// File: rtl/dce_switch_ctrl.sv
// analog switch driver: software set, or all switches owned by the converter, closing at most one
`timescale 1ns/1ps
`include "dce_defines.svh"
module dce_switch_ctrl (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_conv_enable,
   input wire logic [3:0] i_conv_channel,
   input wire logic [`DCE_NUM_SW-1:0] i_soft_set,
   output logic [`DCE_NUM_SW-1:0] o_analog_switch_set
);
   logic [`DCE_NUM_SW-1:0] sw_reg;
   logic [`DCE_NUM_SW-1:0] sw_next;
   always_comb begin
      sw_next = i_soft_set;
      if (i_conv_enable) begin
         sw_next = '0; // RULE6
         if (i_conv_channel < 4'(`DCE_NUM_SW)) begin
            sw_next[i_conv_channel] = 1'b1; // RULE6
         end
      end
   end
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         sw_reg <= '0;
      end else begin
         sw_reg <= sw_next;
      end
   end
   assign o_analog_switch_set = sw_reg;
endmodule : dce_switch_ctrl

// File: rtl/dce_top.sv
// comparator control, event flags, wakeup and register slave
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dce_defines.svh"
module dce_top (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic i_first_comparator,
   input wire logic i_second_comparator,
   input wire logic i_conv_enable,
   input wire logic [3:0] i_conv_channel,
   input wire logic i_halt_mode,
   output logic o_first_irq,
   output logic o_second_irq,
   output logic o_wakeup,
   output logic o_first_enable,
   output logic o_second_enable,
   output logic o_second_fast,
   output logic [2:0] o_second_inverting_source,
   output logic o_reference_to_first_inverting,
   output logic o_window_enable,
   output logic o_reference_out_enable,
   output logic o_timer_two_capture,
   output logic o_timer_three_capture,
   output logic o_timer_one_break_input,
   output logic o_timer_one_reference_clear,
   output logic [`DCE_NUM_SW-1:0] o_analog_switch_set
);
   dce_pkg::dce_cmp_cfg_type first_reg;
   dce_pkg::dce_cmp_cfg_type first_next;
   dce_pkg::dce_cmp_cfg_type second_reg;
   dce_pkg::dce_cmp_cfg_type second_next;
   dce_pkg::dce_shared_type shared_reg;
   dce_pkg::dce_shared_type shared_next;
   logic first_flag_reg;
   logic first_flag_next;
   logic second_flag_reg;
   logic second_flag_next;
   logic [`DCE_NUM_SW-1:0] swsoft_reg;
   logic [`DCE_NUM_SW-1:0] swsoft_next;
   logic ulp_reg;
   logic ulp_next;
   dce_pkg::dce_bus_state_type st_reg;
   dce_pkg::dce_bus_state_type st_next;
   logic aw_got_reg;
   logic aw_got_next;
   logic w_got_reg;
   logic w_got_next;
   logic [31:0] waddr_reg;
   logic [31:0] waddr_next;
   logic [31:0] wdata_reg;
   logic [31:0] wdata_next;
   logic [3:0] wstrb_reg;
   logic [3:0] wstrb_next;
   logic [1:0] bresp_reg;
   logic [1:0] bresp_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [1:0] rresp_reg;
   logic [1:0] rresp_next;
   logic [1:0] out_q_reg;
   logic [1:0] out_q_next;
   logic first_level;
   logic second_level;
   logic first_event;
   logic second_event;
   logic wr_fire;
   logic [31:0] wa;
   logic [31:0] wd;
   logic [7:0] rd_byte;

   // one synchroniser and edge detector per comparator
   dce_edge_detect u_first (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_cmp_out(i_first_comparator),
      .i_edge_sel(first_reg.edge_sel),
      .o_level(first_level),
      .o_event(first_event)
   ); // RULE2
   dce_edge_detect u_second (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_cmp_out(i_second_comparator),
      .i_edge_sel(second_reg.edge_sel),
      .o_level(second_level),
      .o_event(second_event)
   ); // RULE2 RULE13
   dce_switch_ctrl u_switch (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_conv_enable(i_conv_enable),
      .i_conv_channel(i_conv_channel),
      .i_soft_set(swsoft_reg),
      .o_analog_switch_set(o_analog_switch_set)
   );

   // bus handshake: each address/data accepted once, in either order
   assign s_axi_awready = (st_reg == dce_pkg::DCE_IDLE) & ~aw_got_reg;
   assign s_axi_wready = (st_reg == dce_pkg::DCE_IDLE) & ~w_got_reg;
   // a read waits while a write is offered, so it is never taken and lost
   assign s_axi_arready = (st_reg == dce_pkg::DCE_IDLE) & ~aw_got_reg
      & ~w_got_reg & ~s_axi_awvalid & ~s_axi_wvalid;
   assign s_axi_bvalid = (st_reg == dce_pkg::DCE_WRESP);
   assign s_axi_rvalid = (st_reg == dce_pkg::DCE_RRESP);
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;

   always_comb begin
      wa = s_axi_awvalid & s_axi_awready ? s_axi_awaddr : waddr_reg;
      wd = s_axi_wvalid & s_axi_wready ? s_axi_wdata : wdata_reg;
      wr_fire = (aw_got_reg | (s_axi_awvalid & s_axi_awready))
         & (w_got_reg | (s_axi_wvalid & s_axi_wready))
         & (st_reg == dce_pkg::DCE_IDLE);
   end

   always_comb begin
      st_next = st_reg;
      aw_got_next = aw_got_reg;
      w_got_next = w_got_reg;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bresp_next = bresp_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      rd_byte = 8'h00;
      first_next = first_reg;
      second_next = second_reg;
      shared_next = shared_reg;
      swsoft_next = swsoft_reg;
      ulp_next = ulp_reg;
      first_flag_next = first_flag_reg;
      second_flag_next = second_flag_reg;
      case (st_reg)
         dce_pkg::DCE_IDLE: begin
            if (s_axi_awvalid & s_axi_awready) begin
               aw_got_next = 1'b1;
               waddr_next = s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
               w_got_next = 1'b1;
               wdata_next = s_axi_wdata;
               wstrb_next = s_axi_wstrb;
            end
            if (wr_fire) begin
               aw_got_next = 1'b0;
               w_got_next = 1'b0;
               st_next = dce_pkg::DCE_WRESP;
               bresp_next = `DCE_RESP_OKAY;
               // only the byte lane zero strobe gates writes, though switch bits 14:8 sit in lane one
               if ((s_axi_wvalid & s_axi_wready ? s_axi_wstrb[0]
                     : wstrb_reg[0])) begin
                  case ({wa[31:2], 2'b00})
                     `DCE_OFS_FIRST: begin
                        first_next.irq_en = wd[`DCE_BIT_IE];
                        first_next.aux = wd[`DCE_BIT_AUX];
                        first_next.edge_sel = wd[1:0]; // RULE10
                        if (!wd[`DCE_BIT_EF]) begin
                           first_flag_next = 1'b0; // RULE23
                        end
                     end
                     `DCE_OFS_SECOND: begin
                        second_next.irq_en = wd[`DCE_BIT_IE];
                        second_next.aux = wd[`DCE_BIT_AUX]; // RULE5
                        second_next.edge_sel = wd[1:0];
                        if (!wd[`DCE_BIT_EF]) begin
                           second_flag_next = 1'b0; // RULE23
                        end
                     end
                     `DCE_OFS_SHARED: begin
                        shared_next = wd[7:0]; // RULE4 RULE11
                     end
                     `DCE_OFS_SWITCH: begin
                        swsoft_next = wd[`DCE_NUM_SW-1:0];
                     end
                     `DCE_OFS_POWER: begin
                        ulp_next = wd[0];
                     end
                     default: begin
                        bresp_next = `DCE_RESP_SLVERR;
                     end
                  endcase
               end else if ({wa[31:2], 2'b00} > `DCE_OFS_POWER) begin
                  bresp_next = `DCE_RESP_SLVERR;
               end
            end else if (s_axi_arvalid & s_axi_arready) begin
               st_next = dce_pkg::DCE_RRESP;
               rresp_next = `DCE_RESP_OKAY;
               rdata_next = 32'h0000_0000;
               case ({s_axi_araddr[31:2], 2'b00})
                  `DCE_OFS_FIRST: begin
                     rd_byte = {2'b00, first_reg.irq_en, first_flag_reg,
                        first_level, first_reg.aux,
                        first_reg.edge_sel}; // RULE25
                     rdata_next = {24'h00_0000, rd_byte};
                  end
                  `DCE_OFS_SECOND: begin
                     rd_byte = {2'b00, second_reg.irq_en, second_flag_reg,
                        second_level, second_reg.aux,
                        second_reg.edge_sel}; // RULE25
                     rdata_next = {24'h00_0000, rd_byte};
                  end
                  `DCE_OFS_SHARED: begin
                     rdata_next = {24'h00_0000, shared_reg};
                  end
                  `DCE_OFS_SWITCH: begin
                     rdata_next = {17'h0_0000, o_analog_switch_set};
                  end
                  `DCE_OFS_POWER: begin
                     rdata_next = {31'h0000_0000, ulp_reg};
                  end
                  default: begin
                     rresp_next = `DCE_RESP_SLVERR;
                  end
               endcase
            end
         end
         dce_pkg::DCE_WRESP: begin
            if (s_axi_bready) begin
               st_next = dce_pkg::DCE_IDLE;
            end
         end
         dce_pkg::DCE_RRESP: begin
            if (s_axi_rready) begin
               st_next = dce_pkg::DCE_IDLE;
            end
         end
         default: begin
            st_next = dce_pkg::DCE_IDLE;
         end
      endcase
      // a hardware event wins over a software clear in the same cycle
      if (first_event) begin
         first_flag_next = 1'b1; // RULE23
      end
      if (second_event) begin
         second_flag_next = 1'b1; // RULE23
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= dce_pkg::DCE_IDLE;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         waddr_reg <= 32'h0000_0000;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bresp_reg <= `DCE_RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `DCE_RESP_OKAY;
         first_reg <= 4'(`DCE_RST_FIRST); // RULE27
         second_reg <= 4'(`DCE_RST_SECOND); // RULE27
         shared_reg <= `DCE_RST_SHARED;
         swsoft_reg <= '0;
         ulp_reg <= 1'b0;
         first_flag_reg <= 1'b0; // RULE27
         second_flag_reg <= 1'b0; // RULE27
      end else begin
         st_reg <= st_next;
         aw_got_reg <= aw_got_next;
         w_got_reg <= w_got_next;
         waddr_reg <= waddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         bresp_reg <= bresp_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         first_reg <= first_next;
         second_reg <= second_next;
         shared_reg <= shared_next;
         swsoft_reg <= swsoft_next;
         ulp_reg <= ulp_next;
         first_flag_reg <= first_flag_next;
         second_flag_reg <= second_flag_next;
      end
   end

   // interrupt requests and wakeup
   assign o_first_irq = first_flag_reg & first_reg.irq_en; // RULE20
   assign o_second_irq = second_flag_reg & second_reg.irq_en; // RULE21
   // halt wakeup needs the reference running; wait-mode wakeup does not
   assign o_wakeup = (o_first_irq | o_second_irq)
      & ~(i_halt_mode & ulp_reg); // RULE3 RULE17 RULE18 RULE19

   // nonzero edge field enables the analog comparator
   assign o_first_enable = |first_reg.edge_sel; // RULE10
   assign o_second_enable = |second_reg.edge_sel; // RULE1
   assign o_second_fast = second_reg.aux; // RULE5
   assign o_second_inverting_source =
      shared_reg.second_inverting_source; // RULE12
   assign o_reference_to_first_inverting =
      shared_reg.reference_to_first_inverting;
   assign o_window_enable = shared_reg.window_enable; // RULE1 RULE15
   assign o_reference_out_enable = shared_reg.reference_out_enable;

   // timer routing from the synchronised second level, registered
   always_comb begin
      out_q_next = out_q_reg;
      out_q_next[0] = second_level;
      // taken from the next edge field so the route drops with the enable
      out_q_next[1] = |second_next.edge_sel;
   end
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         out_q_reg <= 2'b00;
      end else begin
         out_q_reg <= out_q_next;
      end
   end
   always_comb begin
      o_timer_two_capture = 1'b0;
      o_timer_three_capture = 1'b0;
      o_timer_one_break_input = 1'b0;
      o_timer_one_reference_clear = 1'b0;
      case (shared_reg.second_output_route) // RULE4 RULE24
         `DCE_ROUTE_T2: o_timer_two_capture = &out_q_reg;
         `DCE_ROUTE_T3: o_timer_three_capture = &out_q_reg;
         `DCE_ROUTE_BRK: o_timer_one_break_input = &out_q_reg;
         default: o_timer_one_reference_clear = &out_q_reg;
      endcase
   end
endmodule : dce_top

// File: verif/dce_top_props.sv
// concurrent checks on the comparator event control ports
`timescale 1ns/1ps
`include "dce_defines.svh"
module dce_top_props (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic i_second_comparator,
   input wire logic i_conv_enable,
   input wire logic [3:0] i_conv_channel,
   input wire logic i_halt_mode,
   input wire logic o_first_irq,
   input wire logic o_second_irq,
   input wire logic o_wakeup,
   input wire logic o_first_enable,
   input wire logic o_second_enable,
   input wire logic o_timer_two_capture,
   input wire logic o_timer_three_capture,
   input wire logic o_timer_one_break_input,
   input wire logic o_timer_one_reference_clear,
   input wire logic [`DCE_NUM_SW-1:0] o_analog_switch_set
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   logic [3:0] route;
   assign route = {o_timer_two_capture, o_timer_three_capture,
      o_timer_one_break_input, o_timer_one_reference_clear};
   AST_RESET_QUIET: assert property (disable iff (1'b0) i_rst |->
      !(o_first_enable || o_second_enable || o_first_irq || o_second_irq))
      else $error("outputs active during reset");
   AST_WAKE_CAUSE: assert property (o_wakeup |->
      o_first_irq || o_second_irq) else $error("wakeup without interrupt");
   AST_WAKE_WAIT: assert property (!i_halt_mode &&
      (o_first_irq || o_second_irq) |-> ##[0:1] o_wakeup)
      else $error("interrupt did not wake from wait");
   AST_SW_CONV: assert property (i_conv_enable &&
      i_conv_channel < 4'h0F |=> o_analog_switch_set ==
      (15'h0001 << $past(i_conv_channel))) else $error("switch not owned");
   AST_SW_ONEHOT: assert property ($past(i_conv_enable) |->
      $onehot0(o_analog_switch_set)) else $error("two switches closed");
   AST_ROUTE_ONE: assert property ($onehot0(route))
      else $error("several timer routes active");
   AST_ROUTE_OFF: assert property (!o_second_enable |-> route == 4'h0)
      else $error("route active while disabled");
   AST_SYNC_LOW: assert property ((!i_second_comparator)[*4] |->
      route == 4'h0) else $error("route high with low input");
   AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read response late");
   AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid) else $error("write response repeated");
   AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid) else $error("read response repeated");
   COV_HALT_WAKE: cover property (i_halt_mode && o_wakeup);
   COV_BREAK: cover property (o_timer_one_break_input);
   COV_CONV: cover property (i_conv_enable ##1 i_conv_channel == 4'h0E);
endmodule : dce_top_props
bind dce_top dce_top_props u_props (.*);

// File: verif/dce_analog_model.sv
// behavioural threshold comparator pair driving the block
`timescale 1ns/1ps
module dce_analog_model #(
   parameter int UPPER = 160,
   parameter int LOWER = 80
) (
   input wire logic [7:0] i_vin,
   output logic o_first_comparator,
   output logic o_second_comparator
);
   initial begin
      o_first_comparator = 1'b0;
      o_second_comparator = 1'b0;
   end
   // analog settling lands off the clock edge, like the real thing
   always @(i_vin) begin
      o_first_comparator <= #2 (i_vin > UPPER);
      o_second_comparator <= #2 (i_vin > LOWER);
   end
endmodule : dce_analog_model

// File: verif/dual_comparator_event_control_tb.sv
// self-checking bench for the comparator event control block
`timescale 1ns/1ps
`include "dce_defines.svh"
module dual_comparator_event_control_tb;
   localparam logic [7:0] LOW = 8'h14;
   localparam logic [7:0] MID = 8'h78;
   localparam logic [7:0] HIGH = 8'hC8;
   logic i_ref_clk, i_rst, i_first_comparator, i_second_comparator;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb, i_conv_channel;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, i_conv_enable, i_halt_mode;
   logic o_first_irq, o_second_irq, o_wakeup, o_first_enable;
   logic o_second_enable, o_second_fast, o_reference_to_first_inverting;
   logic o_window_enable, o_reference_out_enable, o_timer_two_capture;
   logic o_timer_three_capture, o_timer_one_break_input;
   logic o_timer_one_reference_clear;
   logic [2:0] o_second_inverting_source;
   logic [`DCE_NUM_SW-1:0] o_analog_switch_set;
   logic [7:0] vin;
   logic [31:0] rd;
   int mismatches, compares;
   dce_top dut (.*);
   dce_analog_model #(.UPPER(160), .LOWER(80)) u_model (.i_vin(vin),
      .o_first_comparator(i_first_comparator),
      .o_second_comparator(i_second_comparator));
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   task automatic print_verdict;
      if (mismatches == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge i_ref_clk);
   endtask : wr
   task automatic rdreg(input logic [31:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge i_ref_clk);
   endtask : rdreg
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      rdreg(a);
      check(rd, exp);
   endtask : rchk
   // comparator edges cross two sync stages; allow them to land
   task automatic settle;
      repeat (6) @(posedge i_ref_clk);
   endtask : settle
   task automatic t_reset;
      rchk(`DCE_OFS_FIRST, 32'h0000_0000);
      rchk(`DCE_OFS_SECOND, 32'h0000_0000);
      rchk(`DCE_OFS_SHARED, 32'h0000_00C0);
      rdreg(32'h0000_0014);
      check(resp, `DCE_RESP_SLVERR);
      wr(32'h0000_0014, 32'h0000_00FF);
      check(resp, `DCE_RESP_SLVERR);
   endtask : t_reset
   task automatic t_edges;
      for (int e = 0; e < 4; e++) begin
         wr(`DCE_OFS_FIRST, 32'(e));
         check(o_first_enable, e != 0);
         vin <= HIGH;
         settle;
         rchk(`DCE_OFS_FIRST, {e[1], 2'b10, e[1:0]});
         wr(`DCE_OFS_FIRST, 32'(e));
         vin <= LOW;
         settle;
         rchk(`DCE_OFS_FIRST, {e[0], 2'b00, e[1:0]});
      end
   endtask : t_edges
   task automatic t_irq;
      wr(`DCE_OFS_FIRST, 32'h0000_0000);
      wr(`DCE_OFS_SECOND, 32'h0000_0023);
      vin <= HIGH;
      settle;
      check({o_second_irq, o_wakeup}, 2'b11);
      i_halt_mode <= 1'b1;
      wr(`DCE_OFS_POWER, 32'h0000_0001);
      check({o_second_irq, o_wakeup}, 2'b10);
      wr(`DCE_OFS_POWER, 32'h0000_0000);
      check(o_wakeup, 1'b1);
      wr(`DCE_OFS_SECOND, 32'h0000_0033);
      check(o_second_irq, 1'b1);
      wr(`DCE_OFS_SECOND, 32'h0000_0003);
      vin <= LOW;
      settle;
      rchk(`DCE_OFS_SECOND, 32'h0000_0013);
      check(o_second_irq, 1'b0);
      i_halt_mode <= 1'b0;
   endtask : t_irq
   task automatic t_route;
      wr(`DCE_OFS_SECOND, 32'h0000_0006);
      check({o_second_fast, o_second_enable}, 2'b11);
      vin <= MID;
      settle;
      for (int r = 0; r < 4; r++) begin
         wr(`DCE_OFS_SHARED, 32'(r) << 6);
         check({o_timer_two_capture, o_timer_three_capture,
            o_timer_one_break_input, o_timer_one_reference_clear},
            4'h8 >> r);
      end
   endtask : t_route
   task automatic t_window;
      wr(`DCE_OFS_SHARED, 32'h0000_0016);
      check({o_second_inverting_source, o_reference_to_first_inverting,
         o_window_enable, o_reference_out_enable}, 6'h16);
      wr(`DCE_OFS_FIRST, 32'h0000_0022);
      wr(`DCE_OFS_SECOND, 32'h0000_0021);
      vin <= HIGH;
      settle;
      check({o_first_irq, o_second_irq}, 2'b10);
      wr(`DCE_OFS_FIRST, 32'h0000_0022);
      vin <= MID;
      settle;
      check({o_first_irq, o_second_irq}, 2'b00);
      vin <= LOW;
      settle;
      check({o_first_irq, o_second_irq}, 2'b01);
   endtask : t_window
   task automatic t_switch;
      wr(`DCE_OFS_SWITCH, 32'h0000_4001);
      check(o_analog_switch_set, 15'h4001);
      i_conv_enable <= 1'b1;
      for (int c = 0; c < 15; c++) begin
         i_conv_channel <= 4'(c);
         repeat (2) @(posedge i_ref_clk);
         check(o_analog_switch_set, 15'h0001 << c);
      end
      i_conv_enable <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      check(o_analog_switch_set, 15'h4001);
   endtask : t_switch
   initial begin
      i_rst = 1'b1;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, i_conv_enable, i_halt_mode} = '0;
      i_conv_channel = 4'h0;
      s_axi_wstrb = 4'hF;
      vin = LOW;
      repeat (5) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
      t_reset;
      t_edges;
      t_irq;
      t_route;
      t_window;
      t_switch;
      print_verdict;
   end
   initial begin
      #100us;
      mismatches++;
      print_verdict;
   end
endmodule : dual_comparator_event_control_tb
